/* sim/obb_pin_model.sv */
// timing pin and comparator model facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module obb_pin_model
  import obb_pkg::*;
(
  // clock
  input  wire logic       clk,
  // switches from the sequencer, bulk sense from the bench
  input  wire obb_drive_t drive,
  input  wire logic [5:0] bulk,
  input  wire logic       slow,
  // comparator levels, raw
  output logic            pin_high = 1'b0,
  output logic            pin_low = 1'b0
);
  // pin level in tenths of a volt
  int v = 0;
  // ***********************************************
  // pin charge and discharge
  // ***********************************************
  // slow mode mimics a large timing capacitor
  always @(posedge clk)
  begin
    if (drive.discharge_switch)
      v = (v > 5) ? v - (slow ? 1 : 5) : 0;
    else if (drive.charge_switch)
      v = v + (slow ? 1 : 5);
    else
      v = int'(bulk); // divider sets the level when idle
    pin_high <= (v >= 45);
    pin_low  <= (v < 9);
  end
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the protection sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import obb_pkg::*;
  // shortened counts keep the run brief
  localparam int BLK = 50;
  localparam int SPK = 10;
  localparam int EXT = 4;
  // stimulus and observation
  logic       clk, rst, ovl, v7, uv, slow, ss;
  logic [5:0] bulk;
  logic       ph, pl;
  obb_drive_t drv;
  obb_mode_t  md;
  obb_cmp_t   cmp;
  int         bad_count = 0;
  int         comparisons = 0;
  int         cyc = 0;
  assign cmp = obb_cmp_t'({ovl, ph, pl, v7, uv});
  // ***********************************************
  // design and far side
  // ***********************************************
  obb_ctrl #(.BLANK_CYC(BLK), .SPIKE_CYC(SPK), .EXT_COUNT(EXT)) u_dut (
    .clk(clk), .rst(rst), .ce(1'b1), .cmp_in(cmp), .drive(drv), .mode(md));
  obb_pin_model u_pin (
    .clk(clk), .drive(drv), .bulk(bulk), .slow(slow),
    .pin_high(ph), .pin_low(pl));
  // ***********************************************
  // clock, timeout and shared tasks
  // ***********************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ceiling well above the several hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // watch a few cycles for the one-cycle soft start pulse
  task automatic catch_ss;
    ss = 1'b0;
    repeat (6)
    begin
      ticks(1);
      if (md.soft_start === 1'b1)
        ss = 1'b1;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic test_startup;
    check(md.brownout, 1'b1);
    check(drv.sink_enable_switch, 1'b0);
    v7 = 1'b1;
    ticks(4);
    check(drv.sink_enable_switch, 1'b1);
    uv = 1'b1;
    ticks(5);
    check(md.switching_en, 1'b0);
    uv = 1'b0;
    ticks(3);
    $display("test startup done");
  endtask
  task automatic test_brownout;
    bulk = 6'h1E;
    ticks(5);
    check({md.brownout, drv.sink_enable_switch}, 2'h0);
    check(md.switching_en, 1'b0);
    uv = 1'b1;
    catch_ss();
    check({ss, md.switching_en}, 2'h3);
    bulk = 6'h05;
    ticks(5);
    check({md.brownout, drv.sink_enable_switch}, 2'h3);
    check(md.switching_en, 1'b0);
    bulk = 6'h1E;
    ticks(5);
    $display("test brownout done");
  endtask
  task automatic test_overload(input logic s);
    int n;
    int chg;
    logic both;
    logic p;
    slow = s;
    ovl = 1'b1;
    n = 0;
    chg = 0;
    both = 1'b0;
    p = 1'b0;
    while (drv.discharge_switch !== 1'b1 && n < 200)
    begin
      ticks(1);
      n++;
    end
    check(n >= BLK + 2 && n <= BLK + 4, 1'b1);
    n = 0;
    while (md.ext_done !== 1'b1 && n < 5000)
    begin
      // an unknown on a switch counts as a clash unless the other switch is low
      if ((drv.charge_switch & drv.discharge_switch) !== 1'b0)
        both = 1'b1;
      if (drv.charge_switch === 1'b1 && !p)
        chg++;
      p = drv.charge_switch;
      ticks(1);
      n++;
    end
    check(chg, EXT);
    check(both, 1'b0);
    check({drv.discharge_switch, drv.charge_switch}, 2'h0);
    n = 0;
    while (md.auto_restart !== 1'b1 && n < 100)
    begin
      ticks(1);
      n++;
    end
    check(n >= SPK && n <= SPK + 2, 1'b1);
    check({md.switching_en, md.fault_detect_en}, 2'h0);
    $display("test overload done");
  endtask
  task automatic test_restart;
    ovl = 1'b0;
    uv = 1'b0;
    ticks(3);
    uv = 1'b1;
    ticks(5);
    check({md.auto_restart, md.restart_odd}, 2'h3);
    check(md.switching_en, 1'b0);
    ovl = 1'b1;
    ticks(BLK + 6);
    check(drv.discharge_switch, 1'b0);
    ovl = 1'b0;
    uv = 1'b0;
    ticks(3);
    uv = 1'b1;
    catch_ss();
    check({ss, md.switching_en, md.auto_restart}, 3'h6);
    check(md.fault_detect_en, 1'b1);
    $display("test restart done");
  endtask
  task automatic test_drop;
    int n;
    ovl = 1'b1;
    n = 0;
    while (drv.charge_switch !== 1'b1 && n < 300)
    begin
      ticks(1);
      n++;
    end
    ovl = 1'b0;
    ticks(5);
    check(drv, 3'h0);
    check({md.ext_done, md.auto_restart}, 2'h0);
    ovl = 1'b1;
    n = 0;
    while (drv.discharge_switch !== 1'b1 && n < 200)
    begin
      ticks(1);
      n++;
    end
    check(n >= BLK + 2 && n <= BLK + 4, 1'b1);
    ovl = 1'b0;
    ticks(5);
    $display("test drop done");
  endtask
  // ***********************************************
  // main sequence
  // ***********************************************
  initial
  begin
    rst = 1'b1;
    ovl = 1'b0;
    v7 = 1'b0;
    uv = 1'b0;
    slow = 1'b0;
    ss = 1'b0;
    bulk = 6'h05;
    ticks(4);
    rst = 1'b0;
    ticks(4);
    test_startup();
    test_brownout();
    test_overload(1'b0);
    test_restart();
    test_drop();
    test_overload(1'b1);
    conclude();
  end
endmodule
`default_nettype wire

/* src/obb_ctrl.sv */
// overload blanking and brownout protection sequencer
`timescale 1ns/100ps
`default_nettype none
`include "obb_regs.svh"
module obb_ctrl
  import obb_pkg::*;
#(
  parameter int unsigned BLANK_CYC = `OBB_BLANK_CYC,
  parameter int unsigned SPIKE_CYC = `OBB_SPIKE_CYC,
  parameter int unsigned EXT_COUNT = `OBB_EXT_COUNT
)(
  // clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // raw comparator levels, asynchronous
  input  wire obb_cmp_t   cmp_in,
  // timing pin switches
  output obb_drive_t      drive,
  // mode outputs
  output obb_mode_t       mode
);
  // ***********************************************
  // elaboration checks
  // ***********************************************
  if (EXT_COUNT < 1 || EXT_COUNT > 511)
    $error("extended count must be 1 to 511");
  if (BLANK_CYC < 1 || SPIKE_CYC < 1)
    $error("timer lengths must be at least one cycle");

  // ***********************************************
  // synchronisers
  // ***********************************************
  obb_cmp_t   sync1_r;            // first stage, read by second only
  obb_cmp_t   cmp_r;              // safe levels
  obb_cmp_t   cmp_d_r;            // previous safe levels for edges

  // two flops on every comparator level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      cmp_r   <= '0;
      cmp_d_r <= '0;
    end
    else if (ce)
    begin
      sync1_r <= cmp_in;
      cmp_r   <= sync1_r;
      cmp_d_r <= cmp_r;
    end
  end

  // edge events on safe levels
  logic uvlo_rise;                // new restart cycle begins
  logic vcc7_rise;                // brownout logic powers up
  logic pin_fall_low;             // pin dropped below 0.9 V
  logic pin_rise_low;             // pin rose past 0.9 V
  assign uvlo_rise    = cmp_r.uvlo_on & ~cmp_d_r.uvlo_on;
  assign vcc7_rise    = cmp_r.vcc_7v & ~cmp_d_r.vcc_7v;
  assign pin_fall_low = cmp_r.pin_low & ~cmp_d_r.pin_low;
  assign pin_rise_low = ~cmp_r.pin_low & cmp_d_r.pin_low;

  // ***********************************************
  // overload blanking sequence
  // ***********************************************
  obb_state_t  state_r;           // blanking sequence state
  obb_state_t  state_nxt;
  logic [31:0] tmr_r;             // fixed and spike timer
  logic [8:0]  extended_cycle_counter;
  logic        ar_r;              // odd skip auto restart active
  logic        odd_r;             // current restart cycle is odd
  logic        fault_det;         // overload may be acted on
  logic        overload_and_gate; // overload and completion
  logic        tmr_end;
  logic        ext_end;

  assign fault_det = ~ar_r;
  assign tmr_end   = (state_r == OBB_FIXED)
                     ? (tmr_r >= BLANK_CYC - 1)
                     : (tmr_r >= SPIKE_CYC - 1);
  assign ext_end   = (extended_cycle_counter
                      == 9'(EXT_COUNT - 1));
  assign overload_and_gate = cmp_r.overload
                             & (state_r inside {OBB_DONE, OBB_SPIKE});

  // next state of the sequence
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      OBB_IDLE:
        // comparator trip starts the fixed window
        if (cmp_r.overload && fault_det)
          state_nxt = OBB_FIXED;
      OBB_FIXED:
        if (tmr_end)
          state_nxt = OBB_DISCH;
      OBB_DISCH:
        // discharge until the pin is at 0.9 V
        if (cmp_r.pin_low)
          state_nxt = OBB_CHARGE;
      OBB_CHARGE:
        // charge to 4.5 V, then count or finish
        if (cmp_r.pin_high)
          state_nxt = ext_end ? OBB_DONE
                              : OBB_DISCH;
      OBB_DONE:
        state_nxt = OBB_SPIKE;
      OBB_SPIKE:
        if (tmr_end)
          state_nxt = OBB_IDLE;
      default:
        state_nxt = OBB_IDLE;
    endcase
    // a vanished overload aborts the whole window
    if (!cmp_r.overload)
      state_nxt = OBB_IDLE;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= OBB_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // fixed and spike timer, restarts on every state change
  always_ff @(posedge clk)
  begin
    if (rst)
      tmr_r <= `OBB_TMR_RST;
    else if (ce)
    begin
      if (state_nxt != state_r)
        tmr_r <= `OBB_TMR_RST;
      else if (state_r inside {OBB_FIXED, OBB_SPIKE})
        tmr_r <= tmr_r + 32'h0000_0001;
    end
  end

  // extended cycle counter
  always_ff @(posedge clk)
  begin
    if (rst)
      extended_cycle_counter <= `OBB_CNT_RST;
    else if (ce)
    begin
      if (state_nxt == OBB_IDLE)
        extended_cycle_counter <= `OBB_CNT_RST;
      else if (state_r == OBB_CHARGE && cmp_r.pin_high && !ext_end)
        extended_cycle_counter <= extended_cycle_counter
                                  + 9'h001;
    end
  end

  // ***********************************************
  // odd skip auto restart
  // ***********************************************
  // entry after spike delay; exit only when an even cycle starts
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ar_r  <= 1'b0;
      odd_r <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r == OBB_SPIKE && tmr_end && overload_and_gate)
      begin
        ar_r  <= 1'b1;
        odd_r <= 1'b0;
      end
      else if (ar_r && uvlo_rise)
      begin
        odd_r <= ~odd_r;
        // an even cycle runs detection and soft start again
        if (odd_r)
          ar_r <= 1'b0;
      end
    end
  end

  // ***********************************************
  // brownout latch
  // ***********************************************
  logic brownout_latch;           // set: switching held off
  logic bo_own_pin;               // pin is free for brownout

  // the blanking sequence owns the pin from discharge through the spike delay
  assign bo_own_pin = (state_r == OBB_IDLE) || (state_r == OBB_FIXED);

  // set wins: setting events are tested first
  always_ff @(posedge clk)
  begin
    if (rst)
      brownout_latch <= 1'b1;
    else if (ce)
    begin
      if (!cmp_r.vcc_7v)
        brownout_latch <= 1'b1;
      else if (vcc7_rise || !cmp_r.uvlo_on && !cmp_d_r.vcc_7v)
        brownout_latch <= 1'b1;
      else if (pin_fall_low && bo_own_pin)
        brownout_latch <= 1'b1;
      else if (pin_rise_low && bo_own_pin)
        brownout_latch <= 1'b0;
    end
  end

  // ***********************************************
  // switching permission
  // ***********************************************
  logic run_r;                    // switching granted this cycle
  logic soft_r;                   // one-cycle soft start request

  // grant only at a turn-on edge, never mid-cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_r  <= 1'b0;
      soft_r <= 1'b0;
    end
    else if (ce)
    begin
      soft_r <= 1'b0;
      if (!cmp_r.uvlo_on || brownout_latch)
        run_r <= 1'b0;
      else if (state_r == OBB_SPIKE && tmr_end && overload_and_gate)
        run_r <= 1'b0;
      else if (uvlo_rise && !(ar_r && !odd_r))
      begin
        run_r  <= 1'b1;
        soft_r <= 1'b1;
      end
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  // registered switch and mode outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive <= '0;
      mode  <= '0;
    end
    else if (ce)
    begin
      drive.discharge_switch   <= (state_nxt == OBB_DISCH);
      drive.charge_switch      <= (state_nxt == OBB_CHARGE);
      drive.sink_enable_switch <= brownout_latch && cmp_r.vcc_7v
                                  && bo_own_pin;
      mode.ext_done        <= (state_nxt inside {OBB_DONE, OBB_SPIKE});
      mode.auto_restart    <= ar_r;
      mode.restart_odd     <= odd_r;
      mode.switching_en    <= run_r && !brownout_latch;
      mode.soft_start      <= soft_r;
      mode.fault_detect_en <= fault_det;
      mode.brownout        <= brownout_latch;
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  fixed_start_a: assert property (
    state_r == OBB_IDLE && cmp_r.overload && !ar_r
    |=> state_r == OBB_FIXED)
    else $error("overload did not start fixed timer");
  ext_start_a: assert property (
    state_r == OBB_FIXED && tmr_end && cmp_r.overload
    |=> state_r == OBB_DISCH)
    else $error("extended phase not entered after fixed time");
  disch_turn_a: assert property (
    state_r == OBB_DISCH && cmp_r.pin_low && cmp_r.overload
    |=> drive.charge_switch && !drive.discharge_switch)
    else $error("charge switch not closed at low threshold");
  count_step_a: assert property (
    state_r == OBB_CHARGE && cmp_r.pin_high && !ext_end
    && cmp_r.overload
    |=> extended_cycle_counter == $past(extended_cycle_counter) + 9'h001)
    else $error("cycle count did not advance");
  done_out_a: assert property (
    state_r == OBB_DONE |-> mode.ext_done)
    else $error("completion output missing");
  switch_excl_a: assert property (
    !(drive.charge_switch && drive.discharge_switch))
    else $error("charge and discharge both closed");
  abort_clear_a: assert property (
    !cmp_r.overload |=> state_r == OBB_IDLE
    && extended_cycle_counter == `OBB_CNT_RST)
    else $error("overload drop did not reset blanking");
  ar_entry_a: assert property (
    state_r == OBB_SPIKE && tmr_end && overload_and_gate |=> ar_r)
    else $error("auto restart not entered after spike delay");
  bo_block_a: assert property (
    brownout_latch |=> !mode.switching_en)
    else $error("switching while brownout latched");
  odd_skip_a: assert property (
    ar_r && !odd_r && uvlo_rise |=> odd_r && ar_r && !soft_r)
    else $error("odd restart cycle was not skipped");
  bo_clear_a: assert property (
    pin_rise_low && bo_own_pin && cmp_r.vcc_7v && cmp_d_r.vcc_7v
    && !pin_fall_low |=> !brownout_latch)
    else $error("brownout latch not cleared");

  ext_run_c:  cover property (state_r == OBB_CHARGE
                              ##[1:40] state_r == OBB_DISCH);
  ar_enter_c: cover property (!ar_r ##1 ar_r);
  bo_exit_c:  cover property (brownout_latch ##1 !brownout_latch);
  even_run_c: cover property (ar_r && odd_r && uvlo_rise);
endmodule
`default_nettype wire

/* src/obb_pkg.sv */
// types for the overload blanking and brownout sequencer
package obb_pkg;
  // comparator levels from the analog side, raw or synchronised
  typedef struct packed {
    logic overload;   // feedback_burst_pin above 4.5 V
    logic pin_high;   // multifunction_timing_pin at 4.5 V
    logic pin_low;    // multifunction_timing_pin below 0.9 V
    logic vcc_7v;     // supply above 7 V
    logic uvlo_on;    // supply reached 17 V turn-on
  } obb_cmp_t;
  // analog switch controls on the timing pin
  typedef struct packed {
    logic discharge_switch;
    logic charge_switch;
    logic sink_enable_switch;
  } obb_drive_t;
  // mode and status toward the controller core
  typedef struct packed {
    logic ext_done;
    logic auto_restart;
    logic restart_odd;
    logic switching_en;
    logic soft_start;
    logic fault_detect_en;
    logic brownout;
  } obb_mode_t;
  // overload blanking sequence
  typedef enum logic [2:0] {
    OBB_IDLE   = 3'b000,
    OBB_FIXED  = 3'b001,
    OBB_DISCH  = 3'b010,
    OBB_CHARGE = 3'b011,
    OBB_DONE   = 3'b100,
    OBB_SPIKE  = 3'b101
  } obb_state_t;
endpackage

/* src/obb_regs.svh */
// constants for the overload blanking and brownout sequencer
`ifndef OBB_REGS_SVH
`define OBB_REGS_SVH
// ***********************************************
// time base and durations
// ***********************************************
`define OBB_CLK_KHZ   200000
`define OBB_BLANK_MS  20
`define OBB_SPIKE_US  30
`define OBB_BLANK_CYC (`OBB_BLANK_MS * `OBB_CLK_KHZ)
`define OBB_SPIKE_CYC ((`OBB_SPIKE_US * `OBB_CLK_KHZ) / 1000)
`define OBB_EXT_COUNT 256
// ***********************************************
// reset values
// ***********************************************
`define OBB_CNT_RST   9'h000
`define OBB_TMR_RST   32'h0000_0000
`endif
